/* File: design/ssims_top.sv */
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module ssims_top
  import ssims_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        NRST,
  // AHB-Lite slave.
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  // Serial link.
  input  wire logic        SCLK_I,
  output logic             SCLK_O,
  output logic             SCLK_OE,
  input  wire logic        RXD,
  output logic             TXD,
  // Events and buffer flags.
  output logic             TRANSMIT_INTERRUPT,
  output logic             RECEIVE_INTERRUPT,
  output logic             TX_BUFFER_EMPTY_FLAG,
  output logic             RX_BUFFER_FULL_FLAG
);

  // Refuse divider widths the register cannot hold.
  if (DIV_W < 1 || DIV_W > 8) begin : g_bad_div
    $error("DIV_W must lie between 1 and 8");
  end

  logic [1:0]       pin_s;
  logic             sclk_s;
  logic             rxd_s;
  logic             sclk_d_q;
  logic             wr_q;
  logic [31:0]      wa_q;
  logic             acc;
  logic             rd_fire;
  logic             rd_rx;
  logic             wr_ctrl;
  logic             wr_stat;
  logic             wr_tx;
  logic             wr_div;
  logic             rxen_rise;
  logic             rx_en_q;
  logic             tx_en_q;
  logic             dbuf_q;
  logic             cint_q;
  logic             edge_q;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] dcnt_q;
  logic             run_q;
  logic             tick;
  logic             sclk_q;
  logic             idle_lvl;
  logic             rise;
  logic             fall;
  logic             lead;
  logic             trail;
  logic             act_q;
  logic [2:0]       bit_q;
  logic             start;
  logic             done;
  logic [7:0]       tx_buf_q;
  logic             txb_v_q;
  logic [7:0]       tx_sh_q;
  logic             txs_v_q;
  logic             tx_have_q;
  logic [7:0]       tx_src;
  logic             tx_data_ok;
  logic             underrun;
  logic             copy;
  logic [7:0]       rx_sh_q;
  logic [7:0]       rx_word;
  logic [7:0]       rx_buf_q;
  logic             rbf_q;
  logic             hold_q;
  logic             req_q;
  logic             rx_dbuf;
  logic             tx_ready;
  logic             rx_ready;
  logic             go;
  logic             oerr_q;
  logic             uerr_q;
  logic [31:0]      rdata_q;
  logic             txd_q;
  logic             tx_int_q;
  logic             rx_int_q;

  // Pin inputs pass two flip-flops before any logic reads them.
  ssims_sync #(
    .W (2)
  ) u_sync (
    .clk  (CLK),
    .nrst (NRST),
    .d    ({SCLK_I, RXD}),
    .q    (pin_s)
  );

  assign sclk_s = pin_s[1];
  assign rxd_s  = pin_s[0];

  // Bus decode: address phase is taken on the edge where HREADY is high.
  assign acc       = HSEL & HTRANS[1] & HREADY;
  assign rd_fire   = acc & !HWRITE;
  assign rd_rx     = rd_fire & (HADDR == OFS_RXBUF);
  assign wr_ctrl   = wr_q & (wa_q == OFS_CTRL);
  assign wr_stat   = wr_q & (wa_q == OFS_STAT);
  assign wr_tx     = wr_q & (wa_q == OFS_TXBUF);
  assign wr_div    = wr_q & (wa_q == OFS_DIV);
  assign rxen_rise = wr_ctrl & HWDATA[CTRL_RXEN] & !rx_en_q;

  // Zero wait state, always OKAY.
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_q;

  // Write address capture for the following data phase.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_q <= 1'b0;
      wa_q <= 32'h0000_0000;
    end else begin
      wr_q <= acc & HWRITE;
      wa_q <= HADDR;
    end
  end

  // Read data is latched at the address edge and stands through the data phase.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_fire) begin
      unique case (HADDR)
        OFS_CTRL:  rdata_q <= {27'h0, edge_q, cint_q, dbuf_q, tx_en_q, rx_en_q};
        OFS_STAT:  rdata_q <= {27'h0, act_q, uerr_q, oerr_q, rbf_q, !txb_v_q};
        OFS_TXBUF: rdata_q <= {24'h0, tx_buf_q};
        OFS_RXBUF: rdata_q <= {24'h0, rx_buf_q};
        OFS_DIV:   rdata_q <= {{(32-DIV_W){1'b0}}, div_q};
        default:   rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Control and divider registers.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rx_en_q <= CTRL_RST[CTRL_RXEN];
      tx_en_q <= CTRL_RST[CTRL_TXEN];
      dbuf_q  <= CTRL_RST[CTRL_DBUF];
      cint_q  <= CTRL_RST[CTRL_CINT];
      edge_q  <= CTRL_RST[CTRL_EDGE];
      div_q   <= DIV_RST[DIV_W-1:0];
    end else begin
      if (wr_ctrl) begin
        rx_en_q <= HWDATA[CTRL_RXEN];
        tx_en_q <= HWDATA[CTRL_TXEN];
        dbuf_q  <= HWDATA[CTRL_DBUF];
        cint_q  <= HWDATA[CTRL_CINT];
        edge_q  <= HWDATA[CTRL_EDGE];
      end
      if (wr_div) begin
        div_q <= HWDATA[DIV_W-1:0];
      end
    end
  end

  // Own shift clock: half period is div_q + 1 system cycles.
  assign tick     = run_q & (dcnt_q == div_q);
  assign idle_lvl = !edge_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dcnt_q <= '0;
    end else if (!run_q || tick) begin
      dcnt_q <= '0;
    end else begin
      dcnt_q <= dcnt_q + 1'b1;
    end
  end

  // Clock level toggles on each tick and rests at the idle level.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sclk_q <= 1'b1;
    end else if (!run_q) begin
      sclk_q <= idle_lvl;
    end else if (tick) begin
      sclk_q <= !sclk_q;
    end
  end

  // Running flag: started by go, ended with the own-clock frame.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      run_q <= 1'b0;
    end else if (!cint_q || (done && cint_q)) begin
      run_q <= 1'b0;
    end else if (go) begin
      run_q <= 1'b1;
    end
  end

  // Edge detection on the synchronised external clock.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sclk_d_q <= 1'b1;
    end else begin
      sclk_d_q <= sclk_s;
    end
  end

  assign rise  = sclk_s & !sclk_d_q;
  assign fall  = !sclk_s & sclk_d_q;
  // Leading edge drives TXD, trailing edge samples RXD; edge_q swaps them.
  assign lead  = cint_q ? (tick & (sclk_q == idle_lvl)) : (edge_q ? rise : fall);
  assign trail = cint_q ? (tick & (sclk_q != idle_lvl)) : (edge_q ? fall : rise);
  assign start = lead & !act_q;
  assign done  = trail & act_q & (bit_q == LAST_BIT);

  // Frame and bit counter; an external clock always starts the counter.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      act_q <= 1'b0;
      bit_q <= 3'h0;
    end else begin
      if (start) begin
        act_q <= 1'b1;
      end else if (done) begin
        act_q <= 1'b0;
      end
      if (start) begin
        bit_q <= 3'h0;
      end else if (trail && act_q) begin
        bit_q <= bit_q + 3'h1;
      end
    end
  end

  // Frame source: buffer, shift register, or all-ones dummy when empty.
  assign tx_data_ok = dbuf_q ? txs_v_q : txb_v_q;
  assign tx_src     = !(tx_en_q && tx_data_ok) ? DUMMY_FRM :
                      (dbuf_q ? tx_sh_q : tx_buf_q);
  assign underrun   = start & tx_en_q & !cint_q & !tx_data_ok;
  assign copy       = dbuf_q & tx_en_q & txb_v_q & !txs_v_q & !act_q & !start;

  // Transmit buffer, shift register and the line, least significant bit first.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tx_buf_q  <= 8'h00;
      txb_v_q   <= 1'b0;
      tx_sh_q   <= DUMMY_FRM;
      txs_v_q   <= 1'b0;
      tx_have_q <= 1'b0;
      txd_q     <= 1'b1;
    end else begin
      if (copy) begin
        tx_sh_q <= tx_buf_q;
        txs_v_q <= 1'b1;
        txb_v_q <= 1'b0;
      end
      if (start) begin
        tx_sh_q   <= tx_src;
        txd_q     <= tx_src[0];
        tx_have_q <= tx_en_q & tx_data_ok;
        if (!dbuf_q) begin
          txb_v_q <= 1'b0;
        end
      end else if (lead && act_q) begin
        txd_q <= tx_sh_q[bit_q];
      end else if (!act_q && !tx_en_q) begin
        txd_q <= 1'b1;
      end
      if (done && dbuf_q) begin
        txs_v_q <= 1'b0;
      end
      if (wr_tx) begin
        tx_buf_q <= HWDATA[7:0];
        txb_v_q  <= 1'b1;
      end
    end
  end

  // Transmit event: end of frame when single, reload when double.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tx_int_q <= 1'b0;
    end else begin
      tx_int_q <= copy | (done & !dbuf_q & tx_have_q);
    end
  end

  // Receive shifting, least significant bit first, on the trailing edge.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rx_sh_q <= 8'h00;
    end else if (trail && act_q && !hold_q) begin
      rx_sh_q[bit_q] <= rxd_s;
    end
  end

  assign rx_word = {rxd_s, rx_sh_q[6:0]};
  // An external clock always uses the receive double buffer.
  assign rx_dbuf = dbuf_q | !cint_q;

  // Receive buffer, full flag, halt state and receive event.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rx_buf_q <= 8'h00;
      rbf_q    <= 1'b0;
      hold_q   <= 1'b0;
      rx_int_q <= 1'b0;
    end else begin
      rx_int_q <= 1'b0;
      if (rd_rx) begin
        if (hold_q) begin
          rx_buf_q <= rx_sh_q;
          hold_q   <= 1'b0;
          rx_int_q <= 1'b1;
        end else begin
          rbf_q <= 1'b0;
        end
      end
      if (done && rx_en_q) begin
        if (!rx_dbuf || !rbf_q || (rd_rx && !hold_q)) begin
          rx_buf_q <= rx_word;
          rbf_q    <= 1'b1;
          rx_int_q <= 1'b1;
        end else if (cint_q) begin
          hold_q <= 1'b1;
        end
      end
    end
  end

  // Receive request: set by enabling reception or reading, used by a start.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      req_q <= 1'b0;
    end else begin
      if (start) begin
        req_q <= 1'b0;
      end
      if (rxen_rise || rd_rx) begin
        req_q <= 1'b1;
      end
    end
  end

  // Own-clock start: every enabled direction must be ready.
  assign tx_ready = dbuf_q ? txs_v_q : txb_v_q;
  assign rx_ready = rx_dbuf ? (tx_en_q ? !rbf_q : !hold_q) : req_q;
  assign go       = cint_q & (tx_en_q | rx_en_q) & !run_q & !act_q &
                    (!tx_en_q | tx_ready) & (!rx_en_q | rx_ready);

  // Error flags: hardware set wins over a software write-one clear.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      oerr_q <= 1'b0;
      uerr_q <= 1'b0;
    end else begin
      if (wr_stat && HWDATA[STAT_OERR]) begin
        oerr_q <= 1'b0;
      end
      if (wr_stat && HWDATA[STAT_UERR]) begin
        uerr_q <= 1'b0;
      end
      if (done && rx_en_q && !cint_q && rbf_q && !rd_rx) begin
        oerr_q <= 1'b1;
      end
      if (underrun) begin
        uerr_q <= 1'b1;
      end
    end
  end

  // Output pins and flags.
  assign SCLK_O               = sclk_q;
  assign SCLK_OE              = cint_q;
  assign TXD                  = txd_q;
  assign TRANSMIT_INTERRUPT   = tx_int_q;
  assign RECEIVE_INTERRUPT    = rx_int_q;
  assign TX_BUFFER_EMPTY_FLAG = !txb_v_q;
  assign RX_BUFFER_FULL_FLAG  = rbf_q;

endmodule

/* File: design/ssims_pkg.sv */
package ssims_pkg;

  // Register byte addresses.
  localparam logic [31:0] OFS_CTRL  = 32'h0000_0000;
  localparam logic [31:0] OFS_STAT  = 32'h0000_0004;
  localparam logic [31:0] OFS_TXBUF = 32'h0000_0008;
  localparam logic [31:0] OFS_RXBUF = 32'h0000_000C;
  localparam logic [31:0] OFS_DIV   = 32'h0000_0010;

  // Control register fields.
  localparam int CTRL_RXEN = 0;
  localparam int CTRL_TXEN = 1;
  localparam int CTRL_DBUF = 2;
  localparam int CTRL_CINT = 3;
  localparam int CTRL_EDGE = 4;

  // Status register fields.
  localparam int STAT_TXEMP = 0;
  localparam int STAT_RBFUL = 1;
  localparam int STAT_OERR  = 2;
  localparam int STAT_UERR  = 3;
  localparam int STAT_BUSY  = 4;

  // Reset values and frame constants.
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] DIV_RST   = 8'h04;
  localparam logic [7:0] DUMMY_FRM = 8'hFF;
  localparam logic [2:0] LAST_BIT  = 3'h7;

endpackage

/* File: design/ssims_sync.sv */
`timescale 1ns/10ps
module ssims_sync #(
  parameter int W = 2
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         nrst,
  // Asynchronous inputs and their synchronised copies.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // Two stages; both reset to the idle high level of the link.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* File: sim/ssims_assertions.sv */
`timescale 1ns/10ps
module ssims_assertions
  import ssims_pkg::*;
(
  // Clock and reset.
  input wire logic        CLK,
  input wire logic        NRST,
  // Bus address and data phases.
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  // Link, events and flags.
  input wire logic        SCLK_O,
  input wire logic        SCLK_OE,
  input wire logic        TXD,
  input wire logic        TRANSMIT_INTERRUPT,
  input wire logic        RECEIVE_INTERRUPT,
  input wire logic        TX_BUFFER_EMPTY_FLAG,
  input wire logic        RX_BUFFER_FULL_FLAG
);
  logic take;
  logic wr_ctrl_q;
  logic wr_tx_q;
  logic cint_q;

  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  // An address phase that the slave accepts.
  assign take = HSEL && HTRANS[1] && HREADY;

  // Follow control and transmit writes into their data phases.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_ctrl_q <= 1'b0;
      wr_tx_q   <= 1'b0;
    end else begin
      wr_ctrl_q <= take && HWRITE && (HADDR == OFS_CTRL);
      wr_tx_q   <= take && HWRITE && (HADDR == OFS_TXBUF);
    end
  end

  // Clock-drive choice carried by the last control write.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cint_q <= 1'b0;
    end else if (wr_ctrl_q) begin
      cint_q <= HWDATA[CTRL_CINT];
    end
  end

  chk_reset_idle: assert property (
    $rose(NRST) |-> TXD && SCLK_O && !SCLK_OE && TX_BUFFER_EMPTY_FLAG && !RX_BUFFER_FULL_FLAG)
    else $error("link not idle after reset");
  chk_tx_pulse: assert property (TRANSMIT_INTERRUPT |=> !TRANSMIT_INTERRUPT)
    else $error("transmit event longer than one cycle");
  chk_rx_pulse: assert property (RECEIVE_INTERRUPT |=> !RECEIVE_INTERRUPT)
    else $error("receive event longer than one cycle");
  chk_rx_full_set: assert property (RECEIVE_INTERRUPT |-> ##[0:1] RX_BUFFER_FULL_FLAG)
    else $error("receive event without a full buffer");
  chk_full_has_event: assert property (
    $rose(RX_BUFFER_FULL_FLAG) |-> RECEIVE_INTERRUPT || $past(RECEIVE_INTERRUPT))
    else $error("buffer filled without a receive event");
  chk_clk_owner: assert property (wr_ctrl_q |-> ##2 SCLK_OE == cint_q)
    else $error("clock drive does not follow control");
  chk_sclk_low: assert property (
    SCLK_OE && $fell(SCLK_O) |-> !SCLK_O [*5] ##1 SCLK_O)
    else $error("own clock low phase not five cycles");
  chk_empty_by_write: assert property (
    $fell(TX_BUFFER_EMPTY_FLAG) |-> $past(wr_tx_q))
    else $error("transmit buffer filled without a write");
endmodule

bind ssims_top ssims_assertions u_chk (
  .CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .SCLK_O(SCLK_O),
  .SCLK_OE(SCLK_OE), .TXD(TXD), .TRANSMIT_INTERRUPT(TRANSMIT_INTERRUPT),
  .RECEIVE_INTERRUPT(RECEIVE_INTERRUPT), .TX_BUFFER_EMPTY_FLAG(TX_BUFFER_EMPTY_FLAG),
  .RX_BUFFER_FULL_FLAG(RX_BUFFER_FULL_FLAG)
);

/* File: sim/ssims_peer.sv */
`timescale 1ns/10ps
module ssims_peer (
  // Link driven by the device.
  input  wire logic       sclk_o,
  input  wire logic       sclk_oe,
  input  wire logic       txd,
  // Link driven by the peer.
  output logic            sclk_i,
  output logic            rxd,
  // Frame data toward and from the bench.
  input  wire logic [7:0] send,
  output logic [7:0]      got,
  output logic [7:0]      fcnt
);
  logic       line;
  logic       prev;
  logic [3:0] nbit;

  // The shift clock on the wire, from whichever side drives it.
  assign line = sclk_oe ? sclk_o : sclk_i;

  // Idle link: clock high, data high.
  initial begin
    sclk_i = 1'b1;
    rxd    = 1'b1;
    prev   = 1'b1;
    nbit   = 4'h0;
    fcnt   = 8'h00;
    got    = 8'h00;
  end

  // Falling edge presents the next bit, rising edge takes the device's bit.
  always @(line) begin
    if (prev === 1'b1 && line === 1'b0) begin
      rxd = send[nbit[2:0]];
    end
    if (prev === 1'b0 && line === 1'b1) begin
      got  = {txd, got[7:1]};
      nbit = nbit + 4'h1;
    end
    if (nbit == 4'h8) begin
      nbit = 4'h0;
      fcnt = fcnt + 8'h01;
      // Hold the last bit 30 ns for the device's synchroniser, then invert it.
      rxd <= #30 ~rxd;
    end
    prev = line;
  end

  // Clocks one frame toward the device at a 125 ns period.
  task automatic ext_frame();
    repeat (8) begin
      #62.5 sclk_i = 1'b0;
      #62.5 sclk_i = 1'b1;
    end
  endtask
endmodule

/* File: sim/tb_sync_serial_io_mode_shifter.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_sync_serial_io_mode_shifter
  import ssims_pkg::*;
;
  logic        clk;
  logic        nrst, hsel, hwrite, hready, sclk_o, sclk_oe, sclk_i, rxd, txd;
  logic        tx_int, rx_int, tx_emp, rx_ful;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  send, got, fcnt, tx;
  int          error_cnt, comparisons, tx_ev, rx_ev, i;
  int          seed = 28142;

  ssims_top u_dut (
    .CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(), .SCLK_I(sclk_i), .SCLK_O(sclk_o),
    .SCLK_OE(sclk_oe), .RXD(rxd), .TXD(txd), .TRANSMIT_INTERRUPT(tx_int),
    .RECEIVE_INTERRUPT(rx_int), .TX_BUFFER_EMPTY_FLAG(tx_emp), .RX_BUFFER_FULL_FLAG(rx_ful)
  );

  ssims_peer u_peer (
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .txd(txd), .sclk_i(sclk_i), .rxd(rxd),
    .send(send), .got(got), .fcnt(fcnt)
  );

  // System clock, 10 ns period.
  always #5 clk = ~clk;

  // Counts the one-cycle event pulses.
  always @(posedge clk) begin
    if (tx_int === 1'b1) tx_ev++;
    if (rx_int === 1'b1) rx_ev++;
  end

  // Expected status word from its four flags.
  function automatic logic [31:0] st(input logic e, input logic f, input logic o, input logic u);
    st = 32'h0;
    st[STAT_TXEMP] = e;
    st[STAT_RBFUL] = f;
    st[STAT_OERR]  = o;
    st[STAT_UERR]  = u;
  endfunction

  // One single bus transfer; read data lands in rd.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  // Reads a register and compares it.
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // Waits, bounded, for the peer to finish frame number n.
  task automatic wait_frame(input logic [7:0] n);
    for (int k = 0; k < 3000 && fcnt !== n; k++) @(posedge clk);
    repeat (12) @(posedge clk);
    `CHK(fcnt, n)
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Cuts a hang short; the tests need well under 100 us.
  initial begin
    #200_000;
    error_cnt++;
    close_out();
  end

  // Main sequence.
  initial begin
    clk    = 1'b0;
    nrst   = 1'b0;
    hsel   = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr  = 32'h0;
    hwdata = 32'h0;
    send   = 8'h00;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(OFS_CTRL, {24'h0, CTRL_RST});
    rdc(OFS_STAT, st(1'b1, 1'b0, 1'b0, 1'b0));
    rdc(OFS_DIV, {24'h0, DIV_RST});
    rdc(32'h0000_0040, 32'h0);
    $display("reset test done");
    // Own clock, receive only: enabling starts a frame, each read starts the next.
    send <= 8'($random(seed));
    bus(1'b1, OFS_CTRL, 32'((1 << CTRL_RXEN) | (1 << CTRL_CINT)));
    for (i = 1; i <= 3; i++) begin
      wait_frame(8'(i));
      `CHK(rx_ev, i)
      `CHK(got, DUMMY_FRM)
      rdc(OFS_STAT, st(1'b1, 1'b1, 1'b0, 1'b0));
      tx = send;
      send <= 8'($random(seed));
      rdc(OFS_RXBUF, {24'h0, tx});
    end
    wait_frame(8'd4);
    bus(1'b1, OFS_CTRL, 32'h0);
    rdc(OFS_RXBUF, {24'h0, send});
    $display("own clock receive test done");
    // External clock, full duplex with random bytes both ways.
    bus(1'b1, OFS_CTRL, 32'((1 << CTRL_RXEN) | (1 << CTRL_TXEN)));
    for (i = 5; i <= 8; i++) begin
      tx = 8'($random(seed));
      send <= 8'($random(seed));
      bus(1'b1, OFS_TXBUF, {24'h0, tx});
      u_peer.ext_frame();
      wait_frame(8'(i));
      `CHK(got, tx)
      `CHK(tx_ev, i - 4)
      `CHK(rx_ev, i)
      rdc(OFS_RXBUF, {24'h0, send});
    end
    $display("external duplex test done");
    // Nothing written: dummy frame and underrun; then an unread buffer overruns.
    tx = 8'($random(seed));
    send <= tx;
    u_peer.ext_frame();
    wait_frame(8'd9);
    `CHK(got, DUMMY_FRM)
    rdc(OFS_STAT, st(1'b1, 1'b1, 1'b0, 1'b1));
    send <= ~tx;
    u_peer.ext_frame();
    wait_frame(8'd10);
    rdc(OFS_STAT, st(1'b1, 1'b1, 1'b1, 1'b1));
    `CHK(rx_ev, 9)
    rdc(OFS_RXBUF, {24'h0, tx});
    bus(1'b1, OFS_STAT, 32'(1 << STAT_OERR | 1 << STAT_UERR));
    rdc(OFS_STAT, st(1'b1, 1'b0, 1'b0, 1'b0));
    $display("error test done");
    // Own clock, double buffer: a second unread frame halts the clock until a read.
    tx = 8'($random(seed));
    send <= tx;
    bus(1'b1, OFS_CTRL, 32'((1 << CTRL_RXEN) | (1 << CTRL_DBUF) | (1 << CTRL_CINT)));
    wait_frame(8'd12);
    `CHK(rx_ev, 10)
    `CHK(rx_ful, 1'b1)
    send <= ~tx;
    rdc(OFS_RXBUF, {24'h0, tx});
    wait_frame(8'd13);
    `CHK(rx_ev, 11)
    bus(1'b1, OFS_CTRL, 32'h0);
    rdc(OFS_RXBUF, {24'h0, tx});
    rdc(OFS_RXBUF, {24'h0, ~tx});
    `CHK(rx_ful, 1'b0)
    $display("double buffer test done");
    close_out();
  end
endmodule
